// ==== ops_pkg.sv ====
`default_nettype none
package ops_pkg;
  // --------------------------------------------------------------
  // Timebase
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 16;
  localparam int MS_PER_S = 1000;
  localparam int MS_W = 10;
  // --------------------------------------------------------------
  // Over-current delay and watchdog period
  // --------------------------------------------------------------
  localparam int OC_DLY_MAX_MS = 255;
  localparam int DLY_W = 8;
  localparam int WDOG_MIN_S = 1;
  localparam int WDOG_MAX_S = 3600;
  localparam int WDOG_DEF_S = 60;
  localparam int WD_W = 12;
  localparam logic [1:0] RSYNC_RST = 2'h0;
  // --------------------------------------------------------------
  // Per-channel state
  // --------------------------------------------------------------
  typedef struct packed {
    logic ov;
    logic oc;
    logic osc;
    logic run;
    logic cc_prev;
    logic [DLY_W-1:0] cnt;
  } ops_ch_st_t;
  localparam ops_ch_st_t CH_RST = '0;
endpackage
`default_nettype wire

// ==== ops_ch_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ops_ch_if #(parameter int VW = 16);
  logic [VW-1:0] vmon;
  logic [VW-1:0] vset;
  logic [VW-1:0] ovlim;
  logic [VW-1:0] offs;
  logic trk_en;
  logic cc;
  logic oc_en;
  logic [ops_pkg::DLY_W-1:0] dly;
  logic start_chg;
  logic set_done;
  logic osc_en;
  logic osc_det;
  logic clr;
  logic tick;
  logic ov;
  logic oc;
  logic osc;
  modport sup (output vmon, vset, ovlim, offs, trk_en, cc, oc_en, dly, start_chg,
    set_done, osc_en, osc_det, clr, tick, input ov, oc, osc);
  modport ch (input vmon, vset, ovlim, offs, trk_en, cc, oc_en, dly, start_chg,
    set_done, osc_en, osc_det, clr, tick, output ov, oc, osc);
endinterface
`default_nettype wire

// ==== ops_channel.sv ====
`timescale 1ns/100ps
`default_nettype none
module ops_channel #(
  parameter int VW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  ops_ch_if.ch c
);
  ops_pkg::ops_ch_st_t q;
  ops_pkg::ops_ch_st_t d;
  logic [VW:0] thr;
  logic cc_rise;
  logic start;

  // --------------------------------------------------------------
  // Trip logic
  // --------------------------------------------------------------
  always_comb begin
    d = q;
    // Extra bit keeps the tracking sum from wrapping to a low limit
    thr = c.trk_en ? ({1'b0, c.vset} + {1'b0, c.offs}) : {1'b0, c.ovlim}; // RULE2
    cc_rise = c.cc & ~q.cc_prev;
    start = c.oc_en & (c.start_chg ? c.set_done : cc_rise); // RULE7
    d.cc_prev = c.cc;
    if (c.clr) begin
      d.ov = 1'b0; // RULE19
      d.oc = 1'b0;
      d.osc = 1'b0;
      d.run = 1'b0;
    end
    // No enable term: this trip can never be switched off
    if ({1'b0, c.vmon} >= thr) begin
      d.ov = 1'b1; // RULE1 RULE21
    end
    if (!c.oc_en) begin
      d.run = 1'b0; // RULE4
    end else if (start) begin
      d.run = 1'b1;
      d.cnt = c.dly; // RULE6
    end else if (q.run) begin
      // Status is looked at only once the delay has run out
      if (q.cnt == '0) begin
        d.run = 1'b0;
        if (c.cc) begin
          d.oc = 1'b1; // RULE3 RULE5
        end
      end else if (c.tick) begin
        d.cnt = q.cnt - 1'b1; // RULE22
      end
    end
    if (c.osc_en & c.osc_det) begin
      d.osc = 1'b1; // RULE17 RULE18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= ops_pkg::CH_RST;
    end else begin
      q <= d;
    end
  end

  assign c.ov = q.ov;
  assign c.oc = q.oc;
  assign c.osc = q.osc;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ov_reach_a: assert property (({1'b0, c.vmon} >= thr) |=> c.ov) // RULE1
    else $error("over-voltage not tripped");
  trip_hold_a: assert property ((c.ov || c.oc || c.osc) && !c.clr |=> // RULE19
    ({c.ov, c.oc, c.osc} & $past({c.ov, c.oc, c.osc})) == $past({c.ov, c.oc, c.osc}))
    else $error("trip released without clear");
  oc_cause_a: assert property ($rose(q.oc) |-> $past(q.run) && $past(q.cnt) == '0 && $past(c.cc)) // RULE5
    else $error("over-current trip without expired delay");
  oc_off_a: assert property (!c.oc_en && !q.oc |=> !q.oc) // RULE4
    else $error("over-current trip while disabled");
  delay_load_a: assert property (start |=> q.run && q.cnt == $past(c.dly)) // RULE7
    else $error("delay timer not launched");
  osc_trip_a: assert property (c.osc_en && c.osc_det |=> c.osc) // RULE17
    else $error("oscillation not latched");
endmodule
`default_nettype wire

// ==== ops_supervisor.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: Output trips off when its voltage reaches the over-voltage limit.
// RULE2: Tracking mode limit is programmed voltage plus offset, followed continuously.
// RULE3: Enabled over-current trips when current limit reached and regulation enters constant current.
// RULE4: Over-current protection has a per-channel enable.
// RULE5: Constant-current ignored during delay; trip only if still present at expiry.
// RULE6: Over-current delay spans zero to 255 milliseconds.
// RULE7: Per-channel choice: delay starts on any limit entry or setting change.
// RULE8: With coupling on, one trip disables every output.
// RULE9: Enabled watchdog trips all outputs when remote traffic stops for period.
// RULE10: Only remote command traffic restarts the watchdog.
// RULE11: Watchdog trip disables outputs, programmed on/off setting untouched.
// RULE12: Watchdog trip sets questionable protection bit and protection indicator.
// RULE13: Watchdog period in whole seconds from one to 3600.
// RULE14: Watchdog period is sixty seconds after reset.
// RULE15: Watchdog settings volatile but readable for saving and recall.
// RULE16: Watchdog trip stays latched until protection clear.
// RULE17: Enabled oscillation detection latches output off and reports it.
// RULE18: Oscillation protection enabled per channel.
// RULE19: Every trip latches and holds output off until cleared.
// RULE20: Host removes fault cause before issuing protection clear.
// RULE21: Over-voltage protection is always active.
// RULE22: Timers run on a millisecond tick derived from the clock.
module ops_supervisor #(
  parameter int N = 4,
  parameter int VW = 16,
  parameter int TICK_CYC = ops_pkg::TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [N*VW-1:0] VOLT_MON,
  input wire logic [N*VW-1:0] VOLT_SET,
  input wire logic [N*VW-1:0] OV_LIMIT,
  input wire logic [N*VW-1:0] OV_TRACK_OFFSET,
  input wire logic [N-1:0] OV_TRACK_EN,
  input wire logic [N-1:0] CONSTANT_CURRENT_REGULATION,
  input wire logic [N-1:0] OVERCURRENT_EN,
  input wire logic [N*ops_pkg::DLY_W-1:0] OC_DELAY_MS,
  input wire logic [N-1:0] START_ON_SETTING_CHANGE,
  input wire logic [N-1:0] SETTING_CHANGE_DONE,
  input wire logic [N-1:0] OSC_EN,
  input wire logic [N-1:0] OSC_DETECT,
  input wire logic [N-1:0] OUT_ON_PROG,
  input wire logic [N-1:0] PROT_CLEAR,
  input wire logic COUPLE_EN,
  input wire logic WDOG_EN,
  input wire logic [ops_pkg::WD_W-1:0] WDOG_PERIOD_S,
  input wire logic WDOG_PERIOD_LOAD,
  input wire logic REMOTE_CMD_ACTIVITY,
  output logic [N-1:0] OUT_ENABLE,
  output logic [N-1:0] OVERVOLTAGE_TRIP,
  output logic [N-1:0] OVERCURRENT_TRIP,
  output logic [N-1:0] OSCILLATION_TRIP,
  output logic [N-1:0] PROT_TRIP,
  output logic [ops_pkg::WD_W-1:0] WDOG_PERIOD,
  output logic QUES_PROT,
  output logic PROT_LED
);
  // --------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------
  if (N < 1 || N > 16) begin : g_bad_n
    $error("channel count out of range");
  end
  if (VW < 2) begin : g_bad_vw
    $error("voltage width too small");
  end
  if (TICK_CYC < 1 || TICK_CYC > (1 << ops_pkg::TICK_W)) begin : g_bad_tick
    $error("tick divider out of range");
  end

  typedef struct packed {
    logic [N-1:0] cc_s1;
    logic [N-1:0] cc_s2;
    logic [N-1:0] osc_s1;
    logic [N-1:0] osc_s2;
    logic [ops_pkg::TICK_W-1:0] tick_cnt;
    logic [ops_pkg::MS_W-1:0] ms_cnt;
    logic [ops_pkg::WD_W-1:0] sec_cnt;
    logic [ops_pkg::WD_W-1:0] period;
    logic wd_trip;
    logic [N-1:0] prot;
    logic [N-1:0] out_en;
    logic ques;
  } ops_top_st_t;

  localparam logic [ops_pkg::TICK_W-1:0] TICK_LAST = ops_pkg::TICK_W'(TICK_CYC - 1);
  localparam logic [ops_pkg::MS_W-1:0] MS_LAST = ops_pkg::MS_W'(ops_pkg::MS_PER_S - 1);
  localparam logic [ops_pkg::WD_W-1:0] WD_MIN = ops_pkg::WD_W'(ops_pkg::WDOG_MIN_S);
  localparam logic [ops_pkg::WD_W-1:0] WD_MAX = ops_pkg::WD_W'(ops_pkg::WDOG_MAX_S);
  localparam logic [ops_pkg::WD_W-1:0] WD_DEF = ops_pkg::WD_W'(ops_pkg::WDOG_DEF_S);
  localparam ops_top_st_t TOP_RST = '{period: WD_DEF, default: '0};

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic [1:0] rsync_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsync_q <= ops_pkg::RSYNC_RST;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // --------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------
  ops_top_st_t q;
  ops_top_st_t d;
  logic tick;
  logic [N-1:0] fault;

  ops_ch_if #(.VW(VW)) chif[N] ();

  for (genvar i = 0; i < N; i++) begin : g_ch
    assign chif[i].vmon = VOLT_MON[i*VW +: VW];
    assign chif[i].vset = VOLT_SET[i*VW +: VW];
    assign chif[i].ovlim = OV_LIMIT[i*VW +: VW];
    assign chif[i].offs = OV_TRACK_OFFSET[i*VW +: VW];
    assign chif[i].trk_en = OV_TRACK_EN[i];
    assign chif[i].cc = q.cc_s2[i];
    assign chif[i].oc_en = OVERCURRENT_EN[i];
    assign chif[i].dly = OC_DELAY_MS[i*ops_pkg::DLY_W +: ops_pkg::DLY_W];
    assign chif[i].start_chg = START_ON_SETTING_CHANGE[i];
    assign chif[i].set_done = SETTING_CHANGE_DONE[i];
    assign chif[i].osc_en = OSC_EN[i];
    assign chif[i].osc_det = q.osc_s2[i];
    assign chif[i].clr = PROT_CLEAR[i];
    assign chif[i].tick = tick;
    assign fault[i] = chif[i].ov | chif[i].oc | chif[i].osc;
    assign OVERVOLTAGE_TRIP[i] = chif[i].ov;
    assign OVERCURRENT_TRIP[i] = chif[i].oc;
    assign OSCILLATION_TRIP[i] = chif[i].osc;

    ops_channel #(.VW(VW)) u_ch (
      .clk(CLK),
      .rst_n(rst_n),
      .c(chif[i])
    );
  end

  // --------------------------------------------------------------
  // Supervisor logic
  // --------------------------------------------------------------
  assign tick = (q.tick_cnt == TICK_LAST); // RULE22

  always_comb begin
    d = q;
    // Regulation status and oscillation detector come from the analog side
    d.cc_s1 = CONSTANT_CURRENT_REGULATION;
    d.cc_s2 = q.cc_s1;
    d.osc_s1 = OSC_DETECT;
    d.osc_s2 = q.osc_s1;

    d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1; // RULE22

    // Out-of-range periods are clamped rather than refused
    if (WDOG_PERIOD_LOAD) begin
      if (WDOG_PERIOD_S < WD_MIN) begin
        d.period = WD_MIN; // RULE13
      end else if (WDOG_PERIOD_S > WD_MAX) begin
        d.period = WD_MAX;
      end else begin
        d.period = WDOG_PERIOD_S;
      end
    end

    // Panel and web traffic never reach this input
    if (!WDOG_EN || REMOTE_CMD_ACTIVITY) begin
      d.ms_cnt = '0; // RULE10
      d.sec_cnt = '0;
    end else if (tick && q.sec_cnt < q.period) begin
      if (q.ms_cnt == MS_LAST) begin
        d.ms_cnt = '0;
        d.sec_cnt = q.sec_cnt + 1'b1;
      end else begin
        d.ms_cnt = q.ms_cnt + 1'b1;
      end
    end

    // Any clear also clears the watchdog; a fresh expiry wins
    if (|PROT_CLEAR) begin
      d.wd_trip = 1'b0; // RULE16
    end
    if (WDOG_EN && q.sec_cnt >= q.period) begin
      d.wd_trip = 1'b1; // RULE9
    end

    for (int i = 0; i < N; i++) begin
      if (PROT_CLEAR[i]) begin
        d.prot[i] = 1'b0;
      end
      if (COUPLE_EN && |(fault & ~(N'(1) << i))) begin
        d.prot[i] = 1'b1; // RULE8
      end
    end

    // Programmed on/off is only gated, never rewritten
    d.out_en = OUT_ON_PROG & ~(fault | q.prot | {N{q.wd_trip}}); // RULE11 RULE19
    d.ques = q.wd_trip | (|q.prot); // RULE12
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= TOP_RST; // RULE14 RULE15
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign OUT_ENABLE = q.out_en;
  assign PROT_TRIP = q.prot;
  assign WDOG_PERIOD = q.period; // RULE15
  assign QUES_PROT = q.ques;
  assign PROT_LED = q.ques;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  wdog_expire_a: assert property (WDOG_EN && q.sec_cnt >= q.period |=> q.wd_trip) // RULE9
    else $error("watchdog did not trip");
  wdog_restart_a: assert property (REMOTE_CMD_ACTIVITY |=> q.sec_cnt == '0 && q.ms_cnt == '0) // RULE10
    else $error("activity did not restart watchdog");
  wdog_latch_a: assert property (q.wd_trip && !(|PROT_CLEAR) |=> q.wd_trip) // RULE16
    else $error("watchdog trip released without clear");
  wdog_outs_a: assert property (q.wd_trip |=> OUT_ENABLE == '0) // RULE11
    else $error("outputs on during watchdog trip");
  wdog_flag_a: assert property (q.wd_trip |=> QUES_PROT && PROT_LED) // RULE12
    else $error("protection flag missing");
  couple_all_a: assert property (COUPLE_EN && |fault |=> (q.prot | $past(fault)) == '1) // RULE8
    else $error("coupled trip missed a channel");
  period_range_a: assert property (WDOG_PERIOD_LOAD |=> q.period >= WD_MIN && q.period <= WD_MAX) // RULE13
    else $error("watchdog period out of range");
  fault_off_a: assert property (|fault ##1 |fault |-> (OUT_ENABLE & $past(fault)) == '0) // RULE19
    else $error("tripped output still enabled");
  tick_rate_a: assert property (tick |=> !tick) // RULE22
    else $error("tick too fast");
  out_prog_a: assert property ((OUT_ENABLE & ~$past(OUT_ON_PROG)) == '0) // RULE11
    else $error("output on without program");
  prot_coupled_a: assert property (!COUPLE_EN |=> (q.prot & ~$past(q.prot)) == '0) // RULE8
    else $error("protection set without coupling");
  wdog_idle_a: assert property (!WDOG_EN |=> q.sec_cnt == '0 && !$rose(q.wd_trip)) // RULE9
    else $error("watchdog counting while disabled");
  ms_bound_a: assert property (q.ms_cnt <= MS_LAST) // RULE22
    else $error("millisecond count out of range");
  period_load_a: assert property (WDOG_PERIOD_LOAD && WDOG_PERIOD_S >= WD_MIN && WDOG_PERIOD_S <= WD_MAX |=> // RULE13
    WDOG_PERIOD == $past(WDOG_PERIOD_S))
    else $error("legal period not taken");
  period_hold_a: assert property (!WDOG_PERIOD_LOAD |=> $stable(q.period)) // RULE15
    else $error("period changed without load");
endmodule
`default_nettype wire

// ==== ops_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Remote host: sends command traffic every gap+1 cycles while alive
// ----------------------------------------------------------------
module ops_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alive,
  input wire logic [15:0] gap,
  output logic activity
);
  logic [15:0] cnt_q;
  // Silence is total once alive drops, so the watchdog sees real inactivity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      activity <= 1'b0;
    end else if (!alive) begin
      cnt_q <= 16'h0000;
      activity <= 1'b0;
    end else begin
      activity <= (cnt_q == gap);
      cnt_q <= (cnt_q == gap) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== ops_supervisor_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ops_supervisor_test;
  localparam int N = 4;
  localparam int VW = 16;
  localparam int TC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [N*VW-1:0] vmon = '0, vset = '0, vlim = '1, offs = '0;
  logic [N-1:0] trk = '0, cc = '0, oce = '0, start_on_setting_change = '0, scd = '0;
  logic [N-1:0] osce = '0, oscd = '0, onp = '0, clr = '0;
  logic [N*8-1:0] dly = '0;
  logic cpl = 1'b0, wde = 1'b0, wpl = 1'b0, act, alive = 1'b0;
  logic [11:0] wps = 12'h000;
  logic [N-1:0] oen, ovt, oct, osct, pt;
  logic [11:0] wp;
  logic qp, led;
  logic [15:0] lim, vs, of;
  int n_fail = 0;
  int check_count = 0;
  int seed = 1;
  int d;
  initial forever #12.5 clk = ~clk;
  ops_supervisor #(.N(N), .VW(VW), .TICK_CYC(TC)) ops_supervisor_i (.CLK(clk), .RST_N(rst_n),
    .VOLT_MON(vmon), .VOLT_SET(vset), .OV_LIMIT(vlim), .OV_TRACK_OFFSET(offs), .OV_TRACK_EN(trk),
    .CONSTANT_CURRENT_REGULATION(cc), .OVERCURRENT_EN(oce), .OC_DELAY_MS(dly),
    .START_ON_SETTING_CHANGE(start_on_setting_change), .SETTING_CHANGE_DONE(scd), .OSC_EN(osce), .OSC_DETECT(oscd),
    .OUT_ON_PROG(onp), .PROT_CLEAR(clr), .COUPLE_EN(cpl), .WDOG_EN(wde), .WDOG_PERIOD_S(wps),
    .WDOG_PERIOD_LOAD(wpl), .REMOTE_CMD_ACTIVITY(act), .OUT_ENABLE(oen), .OVERVOLTAGE_TRIP(ovt),
    .OVERCURRENT_TRIP(oct), .OSCILLATION_TRIP(osct), .PROT_TRIP(pt), .WDOG_PERIOD(wp),
    .QUES_PROT(qp), .PROT_LED(led));
  ops_host_model ops_host_model_i (.clk(clk), .rst_n(rst_n), .alive(alive), .gap(16'h03e8),
    .activity(act));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_vec(input logic [N-1:0] a, input logic [N-1:0] e, input string m);
    check_count++;
    if (a !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, e);
    end
  endtask
  task automatic check_word(input logic [11:0] a, input logic [11:0] e, input string m);
    check_count++;
    if (a !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, e);
    end
  endtask
  function automatic logic [N-1:0] outv(input int s);
    case (s)
      0: return ovt;
      1: return oct;
      2: return osct;
      3: return pt;
      default: return {N{qp}};
    endcase
  endfunction
  function automatic logic [N-1:0] exp_oen(input logic [N-1:0] off);
    return onp & ~off;
  endfunction
  function automatic logic [15:0] trk_lim(input logic [15:0] s, input logic [15:0] o);
    return s + o;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_set(input int s, input logic [N-1:0] m, input int lim_c);
    int k;
    for (k = 0; k < lim_c; k++) begin
      cyc(1);
      if ((outv(s) & m) === m) break;
    end
    if (k == lim_c) begin
      n_fail++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic pulse_clear(input logic [N-1:0] m);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= '0;
    cyc(3);
  endtask
  task automatic oc_run(input logic [7:0] dl);
    @(posedge clk);
    dly[23:16] <= dl;
    cc[2] <= 1'b1;
    cyc(int'(dl) * TC - 2);
    check_vec(oct, '0, "oc inside delay");
    wait_set(1, 4'h4, 2 * TC + 8);
    @(posedge clk);
    cc[2] <= 1'b0;
    pulse_clear(4'h4);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    check_vec(oen, '0, "outputs after reset");
    check_word(wp, 12'h03c, "period after reset");
    @(posedge clk);
    onp <= 4'hf;
    cyc(3);
    check_vec(oen, 4'hf, "outputs on");
    for (int i = 0; i < N; i++) begin
      lim = 16'h0100 + 16'($random(seed) & 32'h3fff);
      @(posedge clk);
      vlim[i*VW+:VW] <= lim;
      vmon[i*VW+:VW] <= lim - 16'h0001;
      cyc(4);
      check_vec(ovt, '0, "ov below limit");
      @(posedge clk);
      vmon[i*VW+:VW] <= lim;
      wait_set(0, 4'(1 << i), 3);
      cyc(1);
      check_vec(oen, exp_oen(4'(1 << i)), "ov output off");
      pulse_clear(4'(1 << i));
      check_vec(ovt, 4'(1 << i), "clear with fault present");
      @(posedge clk);
      vmon[i*VW+:VW] <= '0;
      pulse_clear(4'(1 << i));
      check_vec(ovt, '0, "ov cleared");
      check_vec(oen, 4'hf, "outputs back");
    end
    // Tracking limit follows the programmed voltage, so lowering it must trip
    vs = 16'h0010 + 16'($random(seed) & 32'h3fff);
    of = 16'($random(seed) & 32'h00ff);
    @(posedge clk);
    trk[1] <= 1'b1;
    vset[31:16] <= vs;
    offs[31:16] <= of;
    vmon[31:16] <= trk_lim(vs, of) - 16'h0001;
    cyc(4);
    check_vec(ovt, '0, "tracking below limit");
    @(posedge clk);
    vset[31:16] <= vs - 16'h0001;
    wait_set(0, 4'h2, 3);
    @(posedge clk);
    vmon[31:16] <= '0;
    trk[1] <= 1'b0;
    pulse_clear(4'h2);
    @(posedge clk);
    start_on_setting_change[2] <= 1'b1;
    cc[2] <= 1'b1;
    scd[2] <= 1'b1;
    @(posedge clk);
    scd[2] <= 1'b0;
    cyc(10);
    check_vec(oct, '0, "oc disabled");
    @(posedge clk);
    oce[2] <= 1'b1;
    scd[2] <= 1'b1;
    @(posedge clk);
    scd[2] <= 1'b0;
    wait_set(1, 4'h4, 4);
    cyc(1);
    check_vec(oen, 4'hb, "oc output off");
    @(posedge clk);
    cc[2] <= 1'b0;
    pulse_clear(4'h4);
    @(posedge clk);
    cc[2] <= 1'b1;
    cyc(12 * TC);
    check_vec(oct, '0, "cc rise in change mode");
    @(posedge clk);
    cc[2] <= 1'b0;
    start_on_setting_change[2] <= 1'b0;
    cyc(4);
    d = 2 + ($random(seed) & 7);
    oc_run(8'(d));
    oc_run(8'hff);
    @(posedge clk);
    dly[23:16] <= 8'(d);
    cc[2] <= 1'b1;
    cyc(TC);
    @(posedge clk);
    cc[2] <= 1'b0;
    cyc((d + 3) * TC);
    check_vec(oct, '0, "cc gone at expiry");
    @(posedge clk);
    oscd[3] <= 1'b1;
    cyc(6);
    check_vec(osct, '0, "osc disabled");
    @(posedge clk);
    osce[3] <= 1'b1;
    wait_set(2, 4'h8, 4);
    cyc(1);
    check_vec(oen, 4'h7, "osc output off");
    @(posedge clk);
    oscd[3] <= 1'b0;
    cyc(2);
    pulse_clear(4'h8);
    check_vec(osct, '0, "osc cleared");
    @(posedge clk);
    cpl <= 1'b1;
    vmon[15:0] <= vlim[15:0];
    wait_set(3, 4'he, 4);
    cyc(1);
    check_vec(oen, '0, "coupled outputs off");
    @(posedge clk);
    vmon[15:0] <= '0;
    cpl <= 1'b0;
    pulse_clear(4'hf);
    check_vec(pt | ovt, '0, "coupling cleared");
    // Out-of-range periods are clamped; the last load leaves one second
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      wps <= (j == 0) ? 12'h000 : (j == 1) ? 12'hfff : 12'h001;
      wpl <= 1'b1;
      @(posedge clk);
      wpl <= 1'b0;
      cyc(3);
      check_word(wp, (j == 1) ? 12'he10 : 12'h001, "period clamp");
    end
    @(posedge clk);
    alive <= 1'b1;
    wde <= 1'b1;
    cyc(9000);
    check_vec({N{qp}}, '0, "watchdog fed");
    @(posedge clk);
    alive <= 1'b0;
    cyc(2500);
    check_vec({N{qp}}, '0, "watchdog early");
    wait_set(4, 4'hf, 2600);
    cyc(1);
    check_vec(oen, '0, "watchdog outputs off");
    check_vec({N{led}}, 4'hf, "indicator on");
    cyc(200);
    check_vec({N{qp}}, 4'hf, "watchdog latched");
    @(posedge clk);
    wde <= 1'b0;
    pulse_clear(4'h1);
    check_vec({N{qp}}, '0, "watchdog cleared");
    check_vec(oen, 4'hf, "program state kept");
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(3);
    check_word(wp, 12'h03c, "period volatile");
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    check_vec(oen, 4'hf, "outputs after second reset");
    finish_test();
  end
endmodule
`default_nettype wire
